// file: verilog/refsel_pkg.sv
// Package of constants and types for the PLL reference select control.
package refsel_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS_MUX = 8'h17; // Status pin selection.
  localparam logic [7:0] ADDR_REF_CTL    = 8'h1c; // Reference control.
  localparam logic [7:0] ADDR_HOLD_CTL   = 8'h1d; // Holdover/status control.
  localparam logic [7:0] RST_STATUS_MUX  = 8'h00; // Selection ground.
  localparam logic [7:0] RST_REF_CTL     = 8'h00; // All defaults clear.
  localparam logic [7:0] RST_HOLD_CTL    = 8'h80; // Override on by default.
  localparam logic [7:0] READ_UNMAPPED   = 8'h00; // Answer to other offsets.
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_NO_DEGLITCH = 7; // Disable switchover deglitch.
  localparam int BIT_SEL_SECOND  = 6; // Register-selected reference.
  localparam int BIT_USE_PIN     = 5; // Select pin decides.
  localparam int BIT_AUTO        = 4; // Automatic switchover.
  localparam int BIT_STAY        = 3; // Stay on second reference.
  localparam int BIT_PWR_SECOND  = 2; // Second reference power.
  localparam int BIT_PWR_FIRST   = 1; // First reference power.
  localparam int BIT_DIFF        = 0; // Differential reference mode.
  localparam int BIT_EEPROM_OVR  = 7; // Status pin shows EEPROM status.
  localparam int BIT_XTAL        = 6; // Crystal amplifier enable.
  localparam int MUX_HI          = 6; // Top of the 5-bit mux code.
  localparam int MUX_LO          = 2; // Bottom of the mux code.
  localparam int SYNC_STAGES     = 3; // Pin synchroniser depth.
  // ----------------------------------------------------------------
  // Status pin selection codes (low four bits; bit 4 inverts, except both-OK and all-lock)
  // ----------------------------------------------------------------
  localparam logic [3:0] MX_GROUND   = 4'h0;
  localparam logic [3:0] MX_SEL_OK   = 4'h5;
  localparam logic [3:0] MX_UNSEL_OK = 4'h6;
  localparam logic [3:0] MX_FIRST_OK = 4'h7;
  localparam logic [3:0] MX_SECND_OK = 4'h8;
  localparam logic [3:0] MX_BOTH_OK  = 4'h9;
  localparam logic [3:0] MX_ALL_LOCK = 4'ha;
  localparam logic [3:0] MX_VCO_OK   = 4'hb;
  localparam logic [3:0] MX_SEL_REF  = 4'hc;
  localparam logic [3:0] MX_LOCK     = 4'hd;
  localparam logic [3:0] MX_HOLDOVER = 4'he;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Monitor levels from the surrounding PLL, same clock domain.
  typedef struct packed {
    logic first_ok;    // First reference frequency good.
    logic second_ok;   // Second reference frequency good.
    logic lock;        // Digital lock indicator.
    logic holdover;    // Holdover active.
    logic vco_ok;      // VCO frequency good.
    logic eeprom;      // EEPROM status signal.
  } monitor_type;
  // Register access request.
  typedef struct packed {
    logic       wr;    // Write strobe, one cycle.
    logic       rd;    // Read strobe, one cycle.
    logic [7:0] addr;  // Register offset.
    logic [7:0] wdata; // Write data.
  } reg_req_type;
  // Automatic switchover state.
  typedef enum logic {ON_FIRST, ON_SECOND} ref_state_type;
endpackage

// file: verilog/pll_reference_select_control.sv
// PLL reference selection, power, mode and status pin control.
`timescale 1ns/1ps
module pll_reference_select_control
  import refsel_pkg::*;
(
  input  wire logic                   i_mclk,
  input  wire logic                   i_reset,
  input  wire refsel_pkg::reg_req_type i_reg,
  input  wire refsel_pkg::monitor_type i_mon,
  input  wire logic                   i_ref_sel_pin,
  output logic [7:0]                  o_reg_rdata,
  output logic                        o_ref_select,
  output logic                        o_first_ref_power,
  output logic                        o_second_ref_power,
  output logic                        o_diff_mode,
  output logic                        o_deglitch_en,
  output logic                        o_crystal_amplifier_en,
  output logic                        o_status_pin
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]          ref_ctl_r;   // Reference control register.
  logic [7:0]          hold_ctl_r;  // Holdover/status control register.
  logic [7:0]          mux_r;       // Status pin selection register.
  logic [SYNC_STAGES-1:0] pin_sync_r; // Select pin synchroniser.
  logic                pin_r;       // Filtered select pin level.
  ref_state_type       state_r;     // Automatic switchover state.
  ref_state_type       state_nxt;   // Next automatic state.
  logic                auto_act;    // Automatic switchover in force.
  logic                sel_nxt;     // Next selected reference.
  logic [4:0]          mux_code;    // Status pin mux code.
  logic                mux_val;     // Uninverted mux level.
  logic                status_nxt;  // Next status pin level.

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Each register takes a full byte on its write strobe.
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      ref_ctl_r  <= RST_REF_CTL;
      hold_ctl_r <= RST_HOLD_CTL;
      mux_r      <= RST_STATUS_MUX;
    end
    else if (i_reg.wr)
    begin
      if (i_reg.addr == ADDR_REF_CTL)
      begin
        ref_ctl_r <= i_reg.wdata;
      end
      else if (i_reg.addr == ADDR_HOLD_CTL)
      begin
        hold_ctl_r <= i_reg.wdata;
      end
      else if (i_reg.addr == ADDR_STATUS_MUX)
      begin
        mux_r <= i_reg.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Read data appears one cycle after the strobe and then holds.
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_reg_rdata <= READ_UNMAPPED;
    end
    else if (i_reg.rd)
    begin
      if (i_reg.addr == ADDR_REF_CTL)
      begin
        o_reg_rdata <= ref_ctl_r;
      end
      else if (i_reg.addr == ADDR_HOLD_CTL)
      begin
        o_reg_rdata <= hold_ctl_r;
      end
      else if (i_reg.addr == ADDR_STATUS_MUX)
      begin
        o_reg_rdata <= mux_r;
      end
      else
      begin
        o_reg_rdata <= READ_UNMAPPED;
      end
    end
  end

  // ----------------------------------------------------------------
  // Select pin synchroniser
  // ----------------------------------------------------------------
  // The pin is asynchronous; a change counts once stages two and
  // three agree, which also rejects a single-cycle glitch.
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      pin_sync_r <= '0;
      pin_r      <= 1'b0;
    end
    else
    begin
      pin_sync_r <= {pin_sync_r[SYNC_STAGES-2:0], i_ref_sel_pin};
      if (pin_sync_r[SYNC_STAGES-2] == pin_sync_r[SYNC_STAGES-1])
      begin
        pin_r <= pin_sync_r[SYNC_STAGES-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference selection
  // ----------------------------------------------------------------
  // Auto mode is meaningless in differential mode, so it is gated.
  assign auto_act = ref_ctl_r[BIT_AUTO] & ~ref_ctl_r[BIT_DIFF];

  // Automatic state moves on monitor status; sticky bit blocks return.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ON_FIRST:
      begin
        if (!i_mon.first_ok && i_mon.second_ok)
        begin
          state_nxt = ON_SECOND;
        end
      end
      ON_SECOND:
      begin
        if (!ref_ctl_r[BIT_STAY] && i_mon.first_ok)
        begin
          state_nxt = ON_FIRST;
        end
        // Stay bit set: remain on the second reference.
      end
      default:
      begin
        state_nxt = ON_FIRST;
      end
    endcase
  end

  // Outside auto mode the state rests on the first reference so the
  // next automatic session starts from the default input.
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      state_r <= ON_FIRST;
    end
    else if (!auto_act)
    begin
      state_r <= ON_FIRST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Priority: differential, automatic, pin, register bit.
  always_comb
  begin
    if (ref_ctl_r[BIT_DIFF])
    begin
      sel_nxt = 1'b0;
    end
    else if (auto_act)
    begin
      sel_nxt = (state_r == ON_SECOND);
    end
    else if (ref_ctl_r[BIT_USE_PIN])
    begin
      sel_nxt = pin_r;
    end
    else
    begin
      sel_nxt = ref_ctl_r[BIT_SEL_SECOND];
    end
  end

  // ----------------------------------------------------------------
  // Reference control outputs
  // ----------------------------------------------------------------
  // Power, mode, deglitch and crystal enables follow the registers.
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_ref_select           <= 1'b0;
      o_first_ref_power      <= 1'b0;
      o_second_ref_power     <= 1'b0;
      o_diff_mode            <= 1'b0;
      o_deglitch_en          <= 1'b1;
      o_crystal_amplifier_en <= 1'b0;
    end
    else
    begin
      o_ref_select           <= sel_nxt;
      // Auto overrides both power bits.
      o_first_ref_power      <= auto_act | ref_ctl_r[BIT_PWR_FIRST];
      o_second_ref_power     <= auto_act | ref_ctl_r[BIT_PWR_SECOND];
      o_diff_mode            <= ref_ctl_r[BIT_DIFF];
      o_deglitch_en          <= ~ref_ctl_r[BIT_NO_DEGLITCH];
      o_crystal_amplifier_en <= hold_ctl_r[BIT_XTAL];
    end
  end

  // ----------------------------------------------------------------
  // Status pin multiplexer
  // ----------------------------------------------------------------
  // Clock codes cannot pass through logic and read as low here unless bit 4 inverts them.
  // The two AND codes keep their sense in the inverted half.
  assign mux_code = mux_r[MUX_HI:MUX_LO];

  always_comb
  begin
    case (mux_code[3:0])
      MX_GROUND:   mux_val = 1'b0;
      MX_SEL_OK:   mux_val = o_ref_select ? i_mon.second_ok : i_mon.first_ok;
      MX_UNSEL_OK: mux_val = o_ref_select ? i_mon.first_ok : i_mon.second_ok;
      MX_FIRST_OK: mux_val = i_mon.first_ok;
      MX_SECND_OK: mux_val = i_mon.second_ok;
      MX_BOTH_OK:  mux_val = i_mon.first_ok & i_mon.second_ok;
      MX_ALL_LOCK: mux_val = i_mon.lock & i_mon.vco_ok &
                             (o_ref_select ? i_mon.second_ok : i_mon.first_ok);
      MX_VCO_OK:   mux_val = i_mon.vco_ok;
      MX_SEL_REF:  mux_val = o_ref_select;
      MX_LOCK:     mux_val = i_mon.lock;
      MX_HOLDOVER: mux_val = i_mon.holdover;
      default:     mux_val = 1'b0;
    endcase
    if (hold_ctl_r[BIT_EEPROM_OVR])
    begin
      status_nxt = i_mon.eeprom;
    end
    else if (mux_code[4] && mux_code[3:0] != MX_BOTH_OK &&
             mux_code[3:0] != MX_ALL_LOCK)
    begin
      status_nxt = ~mux_val;
    end
    else
    begin
      status_nxt = mux_val;
    end
  end

  // Registered so the pin never glitches while the mux code changes.
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_status_pin <= 1'b0;
    end
    else
    begin
      o_status_pin <= status_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence no_override_code(logic [4:0] c);
    !hold_ctl_r[BIT_EEPROM_OVR] && mux_code == c;
  endsequence

  sequence back_to_first_ready;
    auto_act && state_r == ON_SECOND && !ref_ctl_r[BIT_STAY] &&
    i_mon.first_ok;
  endsequence

  chk_lock_low: assert property (
    no_override_code({1'b1, MX_LOCK}) |=> o_status_pin == !$past(i_mon.lock))
    else $error("inverted lock code not active low");
  chk_holdover_low: assert property (
    no_override_code({1'b1, MX_HOLDOVER}) |=>
      o_status_pin == !$past(i_mon.holdover))
    else $error("inverted holdover code not active low");
  chk_reg_select: assert property (
    !ref_ctl_r[BIT_DIFF] && !auto_act && !ref_ctl_r[BIT_USE_PIN] |=>
      o_ref_select == $past(ref_ctl_r[BIT_SEL_SECOND]))
    else $error("register select not followed");
  chk_pin_select: assert property (
    !ref_ctl_r[BIT_DIFF] && !auto_act && ref_ctl_r[BIT_USE_PIN] |=>
      o_ref_select == $past(pin_r))
    else $error("select pin not followed");
  chk_auto_power: assert property (
    auto_act |=> o_first_ref_power && o_second_ref_power)
    else $error("auto mode left a reference unpowered");
  chk_manual_power: assert property (
    !auto_act |=> o_first_ref_power == $past(ref_ctl_r[BIT_PWR_FIRST]) &&
      o_second_ref_power == $past(ref_ctl_r[BIT_PWR_SECOND]))
    else $error("manual power bits not followed");
  chk_revert_first: assert property (
    back_to_first_ready ##1 auto_act |-> state_r == ON_FIRST ##1 !o_ref_select)
    else $error("no revert to first reference");
  chk_stay_second: assert property (
    auto_act && state_r == ON_SECOND && ref_ctl_r[BIT_STAY] ##1 auto_act &&
      ref_ctl_r[BIT_STAY] |-> state_r == ON_SECOND ##1 o_ref_select)
    else $error("left second reference in sticky mode");
  chk_diff_mode: assert property (
    ref_ctl_r[BIT_DIFF] |=> o_diff_mode && !o_ref_select)
    else $error("differential mode not applied");
  chk_eeprom_ovr: assert property (
    !$past(i_reset) && hold_ctl_r[BIT_EEPROM_OVR] |=> o_status_pin == $past(i_mon.eeprom))
    else $error("eeprom status not on status pin");
  chk_xtal_en: assert property (
    o_crystal_amplifier_en == $past(hold_ctl_r[BIT_XTAL]))
    else $error("crystal amplifier enable wrong");
  chk_deglitch_en: assert property (
    $rose(ref_ctl_r[BIT_NO_DEGLITCH]) |=> !o_deglitch_en)
    else $error("deglitch not disabled");
endmodule

// file: test/test_pll_reference_select_control.sv
// Self-checking bench for the PLL reference select control block.
`timescale 1ns/1ps
module test_pll_reference_select_control;
  import refsel_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        i_mclk;      // Bench clock.
  logic        i_reset;     // Synchronous reset.
  reg_req_type reg_s;       // Register request.
  monitor_type mon_s;       // Monitor levels.
  logic        pin_s;       // Select pin level.
  logic [7:0]  rdata;       // Read data.
  logic        sel;         // Chosen reference.
  logic        pwr1;        // First reference power.
  logic        pwr2;        // Second reference power.
  logic        diff;        // Differential mode.
  logic        degl;        // Deglitch enable.
  logic        xtal;        // Crystal amplifier enable.
  logic        stat;        // Status pin.
  int          error_cnt;   // Mismatches seen.
  int          total_checks; // Comparisons made.
  int          cycles;      // Cycles since start.
  // ----------------------------------------------------------------
  // Design and clock
  // ----------------------------------------------------------------
  pll_reference_select_control dut_u (
    .i_mclk                 (i_mclk),
    .i_reset                (i_reset),
    .i_reg                  (reg_s),
    .i_mon                  (mon_s),
    .i_ref_sel_pin          (pin_s),
    .o_reg_rdata            (rdata),
    .o_ref_select           (sel),
    .o_first_ref_power      (pwr1),
    .o_second_ref_power     (pwr2),
    .o_diff_mode            (diff),
    .o_deglitch_en          (degl),
    .o_crystal_amplifier_en (xtal),
    .o_status_pin           (stat)
  );
  // The clock toggles every half period of 5 ns.
  always #5 i_mclk = ~i_mclk;
  // A hang is cut short well past the expected run of under two hundred cycles.
  always @(posedge i_mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      error_cnt = error_cnt + 1;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Helper tasks
  // ----------------------------------------------------------------
  // Prints the verdict and ends the run.
  task automatic test_done();
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Compares a register byte.
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Compares a single output level.
  task automatic cmp1(input logic got, input logic exp);
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Lets a number of rising edges pass, then steps off the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // One-cycle write; waits until the outputs have followed it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    reg_s <= '{1'b1, 1'b0, a, d};
    @(posedge i_mclk);
    reg_s.wr <= 1'b0;
    tick(3);
  endtask
  // One-cycle read; data shows at the taking edge and is compared one edge later.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    reg_s <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_mclk);
    reg_s.rd <= 1'b0;
    tick(1);
    cmp8(rdata, exp);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reset values, and writes to an unmapped offset that must be ignored.
  task automatic t_reset_map();
    rd(ADDR_REF_CTL, 8'h00);
    rd(ADDR_HOLD_CTL, 8'h80);
    rd(ADDR_STATUS_MUX, 8'h00);
    cmp1(degl, 1'b1);
    cmp1(stat, 1'b1);
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
    rd(ADDR_REF_CTL, 8'h00);
  endtask
  // Status pin follows the mux once the override is off; inverted codes.
  task automatic t_status();
    wr(ADDR_STATUS_MUX, 8'h34);
    cmp1(stat, 1'b1);
    wr(ADDR_HOLD_CTL, 8'h40);
    cmp1(xtal, 1'b1);
    cmp1(stat, 1'b0);
    mon_s.lock <= 1'b1;
    tick(3);
    cmp1(stat, 1'b1);
    wr(ADDR_STATUS_MUX, 8'h74);
    cmp1(stat, 1'b0);
    mon_s.lock <= 1'b0;
    tick(3);
    cmp1(stat, 1'b1);
    wr(ADDR_STATUS_MUX, 8'h78);
    cmp1(stat, 1'b1);
    mon_s.holdover <= 1'b1;
    tick(3);
    cmp1(stat, 1'b0);
    wr(ADDR_STATUS_MUX, 8'h64);
    cmp1(stat, 1'b1);
    mon_s.second_ok <= 1'b0;
    tick(3);
    cmp1(stat, 1'b0);
    mon_s.second_ok <= 1'b1;
    wr(ADDR_STATUS_MUX, 8'h70);
    cmp1(stat, 1'b1);
    wr(ADDR_STATUS_MUX, 8'h40);
    cmp1(stat, 1'b1);
    wr(ADDR_HOLD_CTL, 8'h80);
    cmp1(xtal, 1'b0);
    cmp1(stat, 1'b1);
  endtask
  // Manual selection, power bits, mode and deglitch control.
  task automatic t_manual();
    wr(ADDR_REF_CTL, 8'h40);
    cmp1(sel, 1'b1);
    wr(ADDR_REF_CTL, 8'h06);
    cmp1(sel, 1'b0);
    cmp1(pwr1, 1'b1);
    cmp1(pwr2, 1'b1);
    wr(ADDR_REF_CTL, 8'h04);
    cmp1(pwr1, 1'b0);
    cmp1(pwr2, 1'b1);
    wr(ADDR_REF_CTL, 8'h01);
    cmp1(diff, 1'b1);
    wr(ADDR_REF_CTL, 8'h80);
    cmp1(diff, 1'b0);
    cmp1(degl, 1'b0);
    wr(ADDR_REF_CTL, 8'h60);
    cmp1(sel, 1'b0);
    pin_s <= 1'b1;
    tick(8);
    cmp1(sel, 1'b1);
    pin_s <= 1'b0;
    tick(8);
    cmp1(sel, 1'b0);
  endtask
  // Automatic switchover, revertive then sticky.
  task automatic t_auto();
    wr(ADDR_REF_CTL, 8'h10);
    cmp1(pwr1, 1'b1);
    cmp1(pwr2, 1'b1);
    cmp1(sel, 1'b0);
    mon_s.first_ok <= 1'b0;
    tick(4);
    cmp1(sel, 1'b1);
    mon_s.first_ok <= 1'b1;
    tick(4);
    cmp1(sel, 1'b0);
    wr(ADDR_REF_CTL, 8'h18);
    mon_s.first_ok <= 1'b0;
    tick(4);
    cmp1(sel, 1'b1);
    mon_s.first_ok <= 1'b1;
    tick(6);
    cmp1(sel, 1'b1);
    wr(ADDR_REF_CTL, 8'h00);
    cmp1(sel, 1'b0);
    cmp1(pwr1, 1'b0);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    i_mclk = 1'b0;
    i_reset = 1'b1;
    reg_s = '0;
    mon_s = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    pin_s = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    cycles = 0;
    repeat (3) @(posedge i_mclk);
    i_reset <= 1'b0;
    tick(2);
    t_reset_map();
    t_status();
    t_manual();
    t_auto();
    test_done();
  end
endmodule
